/* File: sli_pkg.sv */
// Constants for the front-panel status LED block.
// Assumes a 125 MHz system clock; times are held in milliseconds.
package sli_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SLOW_PERIOD_MS = 2000;
  localparam int unsigned FAST_PERIOD_MS = 500;
  localparam longint unsigned SLOW_PERIOD_CYC = longint'(CLK_HZ) * SLOW_PERIOD_MS / 1000;
  localparam longint unsigned FAST_PERIOD_CYC = longint'(CLK_HZ) * FAST_PERIOD_MS / 1000;
  // A period must hold a lit and a dark half and fit the 32-bit counters
  localparam longint unsigned MIN_PERIOD_CYC = 64'h0000_0000_0000_0002;
  localparam longint unsigned MAX_PERIOD_CYC = 64'h0000_0000_ffff_ffff;
  // ----------------------------------------
  // Power LED option encoding
  // ----------------------------------------
  localparam logic OPT_STEADY = 1'h0;
  localparam logic OPT_HEARTBEAT = 1'h1;
  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam int unsigned RELAY_GROUP_W = 5;
  localparam int unsigned INPUT_GROUP_W = 6;
  localparam int unsigned INPUT_SECOND_GROUP_W = 5;
  localparam logic LED_OFF = 1'h0;
  localparam logic LED_ON = 1'h1;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
endpackage

/* File: sli_status_led.sv */
// Front-panel status LED driver: power, relay, input and network LEDs.
// Assumes a single clk_sys; terminal and network states arrive from pins.
//
// What this block does
// - Steady option, no locate: power LED lit continuously.
// - Heartbeat option, no locate: power LED blinks once per two seconds.
// - Locate active: power LED blinks once per half second, overriding options.
// - Steady and heartbeat are exclusive; one option bit selects exactly one.
// - Each relay LED follows its contact: lit closed, off open.
// - Each input LED follows raw terminal state: lit shorted, off open.
// - Link LED lit while communication is enabled and a correct network connection is detected.
// - Communication enabled without link: link LED off, activity LED lit.
// - Communication disabled: link and activity LEDs both off.
// - Activity LED lit while communication active, off when disabled.
`timescale 1ns/1ns
`default_nettype none
module sli_status_led #(
  parameter longint unsigned SLOW_CYC = sli_pkg::SLOW_PERIOD_CYC,
  parameter longint unsigned FAST_CYC = sli_pkg::FAST_PERIOD_CYC,
  parameter int unsigned RELAY_W = sli_pkg::RELAY_GROUP_W,
  parameter int unsigned INPUT_W = sli_pkg::INPUT_GROUP_W,
  parameter int unsigned INPUT2_W = sli_pkg::INPUT_SECOND_GROUP_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic power_led_option,
  input wire logic locate_cmd,
  input wire logic [RELAY_W-1:0] relay_outputs_first_group,
  input wire logic [RELAY_W-1:0] relay_outputs_second_group,
  input wire logic [INPUT_W-1:0] digital_inputs_first_group,
  input wire logic [INPUT2_W-1:0] digital_inputs_second_group,
  input wire logic net_link_ok,
  input wire logic net_comm_enabled,
  output logic power_led,
  output logic [RELAY_W-1:0] relay_led_first,
  output logic [RELAY_W-1:0] relay_led_second,
  output logic [INPUT_W-1:0] input_led_first,
  output logic [INPUT2_W-1:0] input_led_second,
  output logic link_led,
  output logic activity_led
);
  localparam int unsigned NSYNC = 2 * RELAY_W + INPUT_W + INPUT2_W + 4;

  // Refuse parameter sets that the 32-bit counters and the slices cannot serve
  if (SLOW_CYC < sli_pkg::MIN_PERIOD_CYC || FAST_CYC < sli_pkg::MIN_PERIOD_CYC ||
      SLOW_CYC > sli_pkg::MAX_PERIOD_CYC || FAST_CYC > SLOW_CYC) begin : g_bad_period
    $error("sli_status_led: blink periods out of range");
  end
  if (RELAY_W < 1 || INPUT_W < 1 || INPUT2_W < 1) begin : g_bad_width
    $error("sli_status_led: group widths must be positive");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // All inputs come from pins or another domain, so each passes two flops.
  // Flushed on reset so that no stale level reaches an LED after release.
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire [NSYNC-1:0] raw_in = {power_led_option, locate_cmd, net_link_ok, net_comm_enabled,
                             relay_outputs_first_group, relay_outputs_second_group,
                             digital_inputs_first_group, digital_inputs_second_group};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire opt_s = sync_b[NSYNC-1];
  wire locate_s = sync_b[NSYNC-2];
  wire link_s = sync_b[NSYNC-3];
  wire comm_s = sync_b[NSYNC-4];
  wire [RELAY_W-1:0] relay1_s = sync_b[INPUT_W+INPUT2_W+2*RELAY_W-1 -: RELAY_W];
  wire [RELAY_W-1:0] relay2_s = sync_b[INPUT_W+INPUT2_W+RELAY_W-1 -: RELAY_W];
  wire [INPUT_W-1:0] in1_s = sync_b[INPUT_W+INPUT2_W-1 -: INPUT_W];
  wire [INPUT2_W-1:0] in2_s = sync_b[INPUT2_W-1:0];

  // ----------------------------------------
  // Blink counters
  // ----------------------------------------
  // Free running; the phase is not restarted on mode change, so the first
  // flash after a switch may be shortened. Simpler and invisible to a user.
  localparam logic [31:0] SLOW_LAST = 32'(SLOW_CYC - 1);
  localparam logic [31:0] FAST_LAST = 32'(FAST_CYC - 1);
  localparam logic [31:0] SLOW_HALF = 32'(SLOW_CYC / 2);
  localparam logic [31:0] FAST_HALF = 32'(FAST_CYC / 2);

  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;
  wire [31:0] next_slow_cnt = (slow_cnt == SLOW_LAST) ? sli_pkg::CNT_ZERO
                                                      : slow_cnt + sli_pkg::CNT_ONE;
  wire [31:0] next_fast_cnt = (fast_cnt == FAST_LAST) ? sli_pkg::CNT_ZERO
                                                      : fast_cnt + sli_pkg::CNT_ONE;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slow_cnt <= sli_pkg::CNT_ZERO;
      fast_cnt <= sli_pkg::CNT_ZERO;
    end else begin
      slow_cnt <= next_slow_cnt;
      fast_cnt <= next_fast_cnt;
    end
  end

  // Lit during the first half of each period
  wire slow_phase = (slow_cnt < SLOW_HALF);
  wire fast_phase = (fast_cnt < FAST_HALF);

  // ----------------------------------------
  // Power LED selection
  // ----------------------------------------
  // One option bit, so the two options can never both be in force.
  wire opt_value = (opt_s == sli_pkg::OPT_HEARTBEAT) ? slow_phase
                                                     : sli_pkg::LED_ON;
  wire next_power_led = locate_s ? fast_phase : opt_value;

  // ----------------------------------------
  // Network LEDs
  // ----------------------------------------
  wire next_link_led = comm_s & link_s;
  wire next_activity_led = comm_s;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      power_led <= sli_pkg::LED_OFF;
      relay_led_first <= '0;
      relay_led_second <= '0;
      input_led_first <= '0;
      input_led_second <= '0;
      link_led <= sli_pkg::LED_OFF;
      activity_led <= sli_pkg::LED_OFF;
    end else begin
      power_led <= next_power_led;
      relay_led_first <= relay1_s;
      relay_led_second <= relay2_s;
      input_led_first <= in1_s;
      input_led_second <= in2_s;
      link_led <= next_link_led;
      activity_led <= next_activity_led;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic past_ok;
  always_ff @(posedge clk_sys) begin
    if (srst) past_ok <= 1'h0;
    else past_ok <= 1'h1;
  end

  a_steady_lit: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && !locate_s && opt_s == sli_pkg::OPT_STEADY |=> power_led)
    else $error("power LED not steady in steady option");

  a_heartbeat_blink: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && !locate_s && opt_s && slow_cnt == SLOW_HALF |=> !power_led)
    else $error("heartbeat LED not off in second half");

  a_heartbeat_on: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && !locate_s && opt_s && slow_cnt == sli_pkg::CNT_ZERO |=> power_led)
    else $error("heartbeat LED not on at period start");

  a_locate_fast: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && locate_s |=> power_led == $past(fast_phase))
    else $error("locate blink does not follow fast phase");

  a_option_excl: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && !locate_s && opt_s && !slow_phase |=> !power_led)
    else $error("steady lamp shown while heartbeat selected");

  a_relay_follow: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok |=> relay_led_first == $past(relay1_s) && relay_led_second == $past(relay2_s))
    else $error("relay LED does not follow contact");

  a_input_follow: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok |=> input_led_first == $past(in1_s) && input_led_second == $past(in2_s))
    else $error("input LED does not follow terminals");

  a_link_lit: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && comm_s && link_s |=> link_led && activity_led)
    else $error("link LED off with good connection");

  a_nolink_act: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && comm_s && !link_s |=> !link_led && activity_led)
    else $error("bad link indication wrong");

  a_comm_off: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && !comm_s |=> !link_led && !activity_led)
    else $error("network LEDs lit with communication off");

  a_slow_wrap: assert property (@(posedge clk_sys) disable iff (srst)
    slow_cnt == SLOW_LAST |=> slow_cnt == sli_pkg::CNT_ZERO)
    else $error("slow counter period wrong");

  a_fast_wrap: assert property (@(posedge clk_sys) disable iff (srst)
    fast_cnt == FAST_LAST |=> fast_cnt == sli_pkg::CNT_ZERO)
    else $error("fast counter period wrong");

  a_slow_step: assert property (@(posedge clk_sys) disable iff (srst)
    slow_cnt != SLOW_LAST |=> slow_cnt == $past(slow_cnt) + sli_pkg::CNT_ONE)
    else $error("slow counter skipped a count");

  a_fast_step: assert property (@(posedge clk_sys) disable iff (srst)
    fast_cnt != FAST_LAST |=> fast_cnt == $past(fast_cnt) + sli_pkg::CNT_ONE)
    else $error("fast counter skipped a count");

  a_locate_dark: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && locate_s && fast_cnt == FAST_HALF |=> !power_led)
    else $error("locate LED not off in second half");

  a_locate_lit: assert property (@(posedge clk_sys) disable iff (srst)
    past_ok && locate_s && fast_cnt == sli_pkg::CNT_ZERO |=> power_led)
    else $error("locate LED not on at period start");
endmodule
`default_nettype wire

/* File: sli_led_panel.sv */
// Front-panel lamp model: times the blink of the power lamp.
// Assumes power_led is sampled on rising clk_sys edges.
`timescale 1ns/1ns
`default_nettype none
module sli_led_panel (
  input wire logic clk_sys,
  input wire logic power_led,
  output logic [31:0] period,
  output logic [31:0] lit_time
);
  logic [31:0] since_rise = 32'h0;
  logic [31:0] lit_run = 32'h0;
  logic [31:0] period_q = 32'h0;
  logic [31:0] lit_time_q = 32'h0;
  logic last = 1'h0;
  assign period = period_q;
  assign lit_time = lit_time_q;
  // Measures edge to edge, so the counter phase after a mode change does not matter
  always @(posedge clk_sys) begin
    last <= power_led;
    since_rise <= since_rise + 32'h1;
    if (power_led === 1'h1) lit_run <= lit_run + 32'h1;
    if (power_led === 1'h1 && last !== 1'h1) begin
      period_q <= since_rise + 32'h1;
      since_rise <= 32'h0;
      lit_run <= 32'h1;
    end
    if (power_led !== 1'h1 && last === 1'h1) lit_time_q <= lit_run;
  end
endmodule
`default_nettype wire

/* File: status_led_indicator_test.sv */
// Testbench for the status LED block with short blink counts.
// Assumes the three-edge input-to-LED latency of the design.
`timescale 1ns/1ns
`default_nettype none
module status_led_indicator_test;
  logic clk_sys, srst, opt, loc, comm, link;
  logic [4:0] r1, r2, rl1, rl2;
  logic [5:0] i1, il1;
  logic [4:0] i2, il2;
  logic pwr, lk_led, act_led;
  logic [31:0] period, lit_time;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int lit;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  sli_status_led #(.SLOW_CYC(20), .FAST_CYC(8)) uut (.clk_sys(clk_sys), .srst(srst),
    .power_led_option(opt), .locate_cmd(loc), .relay_outputs_first_group(r1),
    .relay_outputs_second_group(r2), .digital_inputs_first_group(i1),
    .digital_inputs_second_group(i2), .net_link_ok(link), .net_comm_enabled(comm),
    .power_led(pwr), .relay_led_first(rl1), .relay_led_second(rl2), .input_led_first(il1),
    .input_led_second(il2), .link_led(lk_led), .activity_led(act_led));
  sli_led_panel panel (.clk_sys(clk_sys), .power_led(pwr), .period(period),
    .lit_time(lit_time));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    srst = 1'h1;
    opt = 1'h0;
    loc = 1'h0;
    comm = 1'h1;
    link = 1'h1;
    r1 = 5'h1f;
    r2 = 5'h1f;
    i1 = 6'h3f;
    i2 = 5'h1f;
    settle(4);
    chk("relay_led_first in reset", 32'h0, {27'h0, rl1});
    chk("link_led in reset", 32'h0, {31'h0, lk_led});
    srst = 1'h0;
    // Contacts and terminals map bit for bit, both polarities
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        r1 = (k == 1) ? 5'h15 : 5'h0a;
        r2 = ~r1;
        i1 = (k == 1) ? 6'h2a : 6'h15;
        i2 = (k == 1) ? 5'h15 : 5'h0a;
      end
      settle(4);
      chk("relay_led_first", {27'h0, r1}, {27'h0, rl1});
      chk("relay_led_second", {27'h0, r2}, {27'h0, rl2});
      chk("input_led_first", {26'h0, i1}, {26'h0, il1});
      chk("input_led_second", {27'h0, i2}, {27'h0, il2});
    end
    // All four link and communication combinations
    for (int k = 0; k < 4; k++) begin
      comm = k[1];
      link = k[0];
      settle(4);
      chk("link_led", {31'h0, k[1] & k[0]}, {31'h0, lk_led});
      chk("activity_led", {31'h0, k[1]}, {31'h0, act_led});
    end
    // Steady lamp must not drop for two full slow periods
    lit = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (pwr === 1'h1) lit++;
    end
    chk("steady lit cycles", 32'h28, lit);
    opt = 1'h1;
    settle(70);
    chk("slow period", 32'h14, period);
    chk("slow lit time", 32'h0a, lit_time);
    // Locate overrides either option
    for (int k = 0; k < 2; k++) begin
      opt = k[0];
      loc = 1'h1;
      settle(40);
      chk("fast period", 32'h8, period);
      chk("fast lit time", 32'h4, lit_time);
    end
    // A second reset in mid-run darkens the LEDs that were lit
    srst = 1'h1;
    settle(2);
    chk("power_led in reset", 32'h0, {31'h0, pwr});
    chk("activity_led in reset", 32'h0, {31'h0, act_led});
    loc = 1'h0;
    opt = 1'h0;
    srst = 1'h0;
    settle(6);
    chk("steady after locate", 32'h1, {31'h0, pwr});
    close_out();
  end
endmodule
`default_nettype wire
